// ---- charger_cfg_pkg.sv ----
package charger_cfg_pkg;

   // Register addresses on the serial control port.
   localparam logic [7:0] ADDR_INPUT_CFG = 8'hC3;
   localparam logic [7:0] ADDR_ADAPTOR_TYPE = 8'hC4;
   localparam logic [7:0] ADDR_SHIP_FET_CFG = 8'hC6;
   localparam logic [7:0] ADDR_ZONE_SPREAD_CFG = 8'hC7;
   localparam logic [7:0] ADDR_PIN_COOL_CFG = 8'hD5;

   // Power-on reset values of the writable registers.
   localparam logic [7:0] RST_INPUT_CFG = 8'h00;
   localparam logic [7:0] RST_SHIP_FET_CFG = 8'h0C;
   localparam logic [7:0] RST_ZONE_SPREAD_CFG = 8'h7C;
   localparam logic [7:0] RST_PIN_COOL_CFG = 8'h08;

   // Implemented bits; every other bit reads zero and drops writes.
   localparam logic [7:0] MASK_INPUT_CFG = 8'h99;
   localparam logic [7:0] MASK_ADAPTOR_TYPE = 8'h7F;
   localparam logic [7:0] MASK_SHIP_FET_CFG = 8'h3E;
   localparam logic [7:0] MASK_ZONE_SPREAD_CFG = 8'hFF;
   localparam logic [7:0] MASK_PIN_COOL_CFG = 8'h0F;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Field positions.
   localparam int BIT_LIMIT_SOURCE_BYPASS = 7;
   localparam int LSB_INPUT_REG_THRESHOLD = 3;
   localparam int BIT_SKIP_MODE_DISABLE = 0;
   localparam int BIT_STANDBY_FORCE = 5;
   localparam int BIT_BATTERY_FET_RESET = 4;
   localparam int BIT_BATTERY_FET_RESET_TIME = 3;
   localparam int BIT_SHIP_DELAY_ENABLE = 2;
   localparam int BIT_SHIP_DELAY_TIME = 1;
   localparam int BIT_EXTREME_ZONE_DISABLE = 7;
   localparam int LSB_WARM_ZONE_VOLTAGE = 5;
   localparam int LSB_COOL_ZONE_CURRENT = 3;
   localparam int BIT_SPREAD_PATTERN = 2;
   localparam int BIT_SPREAD_ENVELOPE = 1;
   localparam int BIT_SPREAD_ENABLE = 0;
   localparam int BIT_COOL_VOLTAGE_REDUCTION = 3;
   localparam int BIT_SECOND_PIN_FUNCTION = 2;
   localparam int BIT_SECOND_PIN_MANUAL_SELECT = 1;
   localparam int BIT_SECOND_PIN_MANUAL_LEVEL = 0;

   // Zone selector codes and their effects.
   localparam logic [1:0] ZONE_CODE_SMALL = 2'h2;
   localparam logic [1:0] ZONE_CODE_LARGE = 2'h3;
   localparam logic [7:0] CV_DROP_NONE_MV = 8'h00;
   localparam logic [7:0] CV_DROP_SMALL_MV = 8'h64;
   localparam logic [7:0] CV_DROP_LARGE_MV = 8'h96;
   localparam logic [7:0] CC_FULL_PERCENT = 8'h64;
   localparam logic [7:0] CC_SMALL_PERCENT = 8'h14;
   localparam logic [7:0] CC_LARGE_PERCENT = 8'h32;

   // Time base for the ship-mode and battery FET delays.
   localparam int CLK_HZ = 10_000_000;
   localparam int DELAY_SHORT_S = 1;
   localparam int DELAY_LONG_S = 5;
   localparam int DELAY_SHORT_CYCLES = CLK_HZ * DELAY_SHORT_S;
   localparam int DELAY_LONG_CYCLES = CLK_HZ * DELAY_LONG_S;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic limit_from_type_c;
      logic [6:0] limit_code;
      logic [1:0] input_regulation_threshold;
      logic skip_mode_auto;
      logic converter_off;
      logic standby;
   } power_ctrl_t;

   typedef struct packed {
      logic extreme_zone_enable;
      logic [7:0] cv_drop_mv;
      logic [7:0] cc_percent;
      logic spread_enable;
      logic spread_pattern;
      logic spread_envelope;
   } thermal_ctrl_t;

endpackage

// ---- charger_config_register_bank.sv ----
`timescale 1ns/1ps
module charger_config_register_bank
   import charger_cfg_pkg::*;
#(
   parameter int SHORT_CYCLES = DELAY_SHORT_CYCLES,
   parameter int LONG_CYCLES = DELAY_LONG_CYCLES
) (
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Register port from the serial control interface.
   input wire reg_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   // Detection and charger state inputs.
   input wire logic [6:0] type_c_limit_code,
   input wire logic [6:0] input_current_limit_code,
   input wire logic [6:0] adaptor_type,
   input wire logic warm_zone,
   input wire logic cool_zone,
   input wire logic current_at_floor,
   input wire logic fault,
   input wire logic detection_done,
   input wire logic ship_mode_request,
   // Control outputs to the power path and charger.
   output power_ctrl_t power_ctrl,
   output thermal_ctrl_t thermal_ctrl,
   output logic battery_fet_off,
   output logic ship_mode_enter,
   // Second status pin, open drain.
   output logic second_status_pin_out,
   output logic second_status_pin_oe
);

   logic [7:0] input_cfg_r;
   logic [7:0] ship_fet_cfg_r;
   logic [7:0] zone_spread_cfg_r;
   logic [7:0] pin_cool_cfg_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic ship_req_prev_r;
   logic fet_bit_prev_r;
   logic ship_mode_r;
   logic fet_off_r;
   power_ctrl_t power_ctrl_r;
   thermal_ctrl_t thermal_ctrl_r;
   logic ship_start;
   logic ship_done;
   logic fet_start;
   logic fet_busy;
   logic [1:0] warm_code;
   logic [1:0] cool_code;
   logic [7:0] warm_drop_mv;

   // The delay timers need a positive short count no larger than the long one.
   if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES) begin : g_bad_cycles
      $error("charger_config_register_bank: bad delay cycle counts");
   end

   // Voltage drop picked by the warm-zone field; the cool path reuses it.
   function automatic logic [7:0] warm_drop(input logic [1:0] code);
      unique case (code)
         ZONE_CODE_SMALL: warm_drop = CV_DROP_SMALL_MV;
         ZONE_CODE_LARGE: warm_drop = CV_DROP_LARGE_MV;
         default: warm_drop = CV_DROP_NONE_MV;
      endcase
   endfunction

   // Register writes; masks keep reserved bits at zero whatever is written.
   always_ff @(posedge clk) begin
      if (reset) begin
         input_cfg_r <= RST_INPUT_CFG;
         ship_fet_cfg_r <= RST_SHIP_FET_CFG;
         zone_spread_cfg_r <= RST_ZONE_SPREAD_CFG;
         pin_cool_cfg_r <= RST_PIN_COOL_CFG;
      end else if (ce && req.wr) begin
         unique case (req.addr)
            ADDR_INPUT_CFG: input_cfg_r <= req.wdata & MASK_INPUT_CFG;
            ADDR_SHIP_FET_CFG: ship_fet_cfg_r <= req.wdata & MASK_SHIP_FET_CFG;
            ADDR_ZONE_SPREAD_CFG: zone_spread_cfg_r <= req.wdata & MASK_ZONE_SPREAD_CFG;
            ADDR_PIN_COOL_CFG: pin_cool_cfg_r <= req.wdata & MASK_PIN_COOL_CFG;
            default: ;
         endcase
      end
   end

   // Read data is registered and marked by a one-cycle valid pulse.
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= READ_UNMAPPED;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         rvalid_r <= req.rd;
         if (req.rd) begin
            unique case (req.addr)
               ADDR_INPUT_CFG: rdata_r <= input_cfg_r;
               ADDR_ADAPTOR_TYPE: rdata_r <= {1'b0, adaptor_type} & MASK_ADAPTOR_TYPE;
               ADDR_SHIP_FET_CFG: rdata_r <= ship_fet_cfg_r;
               ADDR_ZONE_SPREAD_CFG: rdata_r <= zone_spread_cfg_r;
               ADDR_PIN_COOL_CFG: rdata_r <= pin_cool_cfg_r;
               default: rdata_r <= READ_UNMAPPED;
            endcase
         end
      end
   end

   assign rdata = rdata_r;
   assign rvalid = rvalid_r;

   // Power path controls follow the configuration one cycle later.
   always_ff @(posedge clk) begin
      if (reset) begin
         power_ctrl_r <= '0;
      end else if (ce) begin
         power_ctrl_r.limit_from_type_c <= ~input_cfg_r[BIT_LIMIT_SOURCE_BYPASS];
         power_ctrl_r.limit_code <= input_cfg_r[BIT_LIMIT_SOURCE_BYPASS] ?
                                    input_current_limit_code : type_c_limit_code;
         power_ctrl_r.input_regulation_threshold <=
            input_cfg_r[LSB_INPUT_REG_THRESHOLD +: 2];
         power_ctrl_r.skip_mode_auto <= ~input_cfg_r[BIT_SKIP_MODE_DISABLE];
         power_ctrl_r.converter_off <= ship_fet_cfg_r[BIT_STANDBY_FORCE];
         power_ctrl_r.standby <= ship_fet_cfg_r[BIT_STANDBY_FORCE];
      end
   end

   assign power_ctrl = power_ctrl_r;

   assign warm_code = zone_spread_cfg_r[LSB_WARM_ZONE_VOLTAGE +: 2];
   assign cool_code = zone_spread_cfg_r[LSB_COOL_ZONE_CURRENT +: 2];
   assign warm_drop_mv = warm_drop(warm_code);

   // Zone adjustments; warm sets the voltage drop when both zone inputs are asserted at once, while cool still cuts the current.
   always_ff @(posedge clk) begin
      if (reset) begin
         thermal_ctrl_r <= '0;
      end else if (ce) begin
         thermal_ctrl_r.extreme_zone_enable <=
            ~zone_spread_cfg_r[BIT_EXTREME_ZONE_DISABLE];
         if (warm_zone) begin
            thermal_ctrl_r.cv_drop_mv <= warm_drop_mv;
         end else if (cool_zone && current_at_floor &&
                      pin_cool_cfg_r[BIT_COOL_VOLTAGE_REDUCTION]) begin
            thermal_ctrl_r.cv_drop_mv <= warm_drop_mv;
         end else begin
            thermal_ctrl_r.cv_drop_mv <= CV_DROP_NONE_MV;
         end
         if (cool_zone && cool_code == ZONE_CODE_SMALL) begin
            thermal_ctrl_r.cc_percent <= CC_SMALL_PERCENT;
         end else if (cool_zone && cool_code == ZONE_CODE_LARGE) begin
            thermal_ctrl_r.cc_percent <= CC_LARGE_PERCENT;
         end else begin
            thermal_ctrl_r.cc_percent <= CC_FULL_PERCENT;
         end
         thermal_ctrl_r.spread_enable <= zone_spread_cfg_r[BIT_SPREAD_ENABLE];
         thermal_ctrl_r.spread_pattern <= zone_spread_cfg_r[BIT_SPREAD_PATTERN];
         thermal_ctrl_r.spread_envelope <= zone_spread_cfg_r[BIT_SPREAD_ENVELOPE];
      end
   end

   assign thermal_ctrl = thermal_ctrl_r;

   // Edge memories for the two delay requests.
   always_ff @(posedge clk) begin
      if (reset) begin
         ship_req_prev_r <= 1'b0;
         fet_bit_prev_r <= 1'b0;
      end else if (ce) begin
         ship_req_prev_r <= ship_mode_request;
         fet_bit_prev_r <= ship_fet_cfg_r[BIT_BATTERY_FET_RESET];
      end
   end

   assign ship_start = ship_mode_request & ~ship_req_prev_r &
                       ship_fet_cfg_r[BIT_SHIP_DELAY_ENABLE];
   assign fet_start = ship_fet_cfg_r[BIT_BATTERY_FET_RESET] & ~fet_bit_prev_r;

   delay_timer #(
      .SHORT_CYCLES(SHORT_CYCLES),
      .LONG_CYCLES(LONG_CYCLES)
   ) u_ship_timer (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .start(ship_start),
      .sel_long(ship_fet_cfg_r[BIT_SHIP_DELAY_TIME]),
      .abort(~ship_mode_request),
      .busy(),
      .done(ship_done)
   );

   delay_timer #(
      .SHORT_CYCLES(SHORT_CYCLES),
      .LONG_CYCLES(LONG_CYCLES)
   ) u_fet_timer (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .start(fet_start),
      .sel_long(ship_fet_cfg_r[BIT_BATTERY_FET_RESET_TIME]),
      .abort(1'b0),
      .busy(fet_busy),
      .done()
   );

   // Ship mode holds while the request stands; dropping the request cancels it.
   always_ff @(posedge clk) begin
      if (reset) begin
         ship_mode_r <= 1'b0;
      end else if (ce) begin
         if (!ship_mode_request) begin
            ship_mode_r <= 1'b0;
         end else if (!ship_fet_cfg_r[BIT_SHIP_DELAY_ENABLE] || ship_done) begin
            ship_mode_r <= 1'b1;
         end
      end
   end

   // The FET stays off for at least the selected time, even if cleared early.
   always_ff @(posedge clk) begin
      if (reset) begin
         fet_off_r <= 1'b0;
      end else if (ce) begin
         fet_off_r <= ship_fet_cfg_r[BIT_BATTERY_FET_RESET] | fet_start | fet_busy;
      end
   end

   assign ship_mode_enter = ship_mode_r;
   assign battery_fet_off = fet_off_r;

   status_pin_driver u_pin (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .pin_function(pin_cool_cfg_r[BIT_SECOND_PIN_FUNCTION]),
      .manual_select(pin_cool_cfg_r[BIT_SECOND_PIN_MANUAL_SELECT]),
      .manual_level(pin_cool_cfg_r[BIT_SECOND_PIN_MANUAL_LEVEL]),
      .fault(fault),
      .detection_done(detection_done),
      .pin_out(second_status_pin_out),
      .pin_oe(second_status_pin_oe)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_reserved_read_zero: assert property (
      (ce && req.rd && req.addr == ADDR_SHIP_FET_CFG) |=> (rdata[7:6] == 2'h0 && !rdata[0]))
      else $error("reserved bits read non-zero");
   chk_limit_source_mux: assert property (
      (ce && $stable(input_cfg_r) && $stable(input_current_limit_code) &&
       input_cfg_r[BIT_LIMIT_SOURCE_BYPASS]) |=>
      power_ctrl.limit_code == $past(input_current_limit_code))
      else $error("programmed limit not used under bypass");
   chk_standby_force: assert property (
      (ce && ship_fet_cfg_r[BIT_STANDBY_FORCE]) |=>
      (power_ctrl.converter_off && power_ctrl.standby))
      else $error("standby not forced");
   chk_skip_mode: assert property (
      (ce && input_cfg_r[BIT_SKIP_MODE_DISABLE]) |=> !power_ctrl.skip_mode_auto)
      else $error("skip mode not disabled");
   chk_ship_immediate: assert property (
      (ce && ship_mode_request && !ship_fet_cfg_r[BIT_SHIP_DELAY_ENABLE]) |=> ship_mode_enter)
      else $error("immediate ship entry missed");
   chk_ship_not_early: assert property (
      (ce && ship_start && !ship_mode_r) ##1 (ce && ship_mode_request && !ship_start)
      |-> !ship_mode_enter)
      else $error("ship mode entered before delay");
   chk_fet_off_bit: assert property (
      (ce && ship_fet_cfg_r[BIT_BATTERY_FET_RESET]) |=> battery_fet_off)
      else $error("battery FET not turned off");
   chk_warm_drop_large: assert property (
      (ce && warm_zone && warm_code == ZONE_CODE_LARGE) |=>
      thermal_ctrl.cv_drop_mv == CV_DROP_LARGE_MV)
      else $error("warm drop wrong");
   chk_cool_current_small: assert property (
      (ce && cool_zone && cool_code == ZONE_CODE_SMALL) |=>
      thermal_ctrl.cc_percent == CC_SMALL_PERCENT)
      else $error("cool current wrong");
   chk_pin_manual_low: assert property (
      (ce && pin_cool_cfg_r[BIT_SECOND_PIN_MANUAL_SELECT] &&
       pin_cool_cfg_r[BIT_SECOND_PIN_MANUAL_LEVEL]) |=> second_status_pin_oe)
      else $error("manual low not driven");

   cov_ship_delayed: cover property (ship_done ##1 ship_mode_enter);
   cov_fet_reset: cover property (fet_start ##1 battery_fet_off);
   cov_pin_manual: cover property (
      pin_cool_cfg_r[BIT_SECOND_PIN_MANUAL_SELECT] && second_status_pin_oe);

endmodule

// ---- delay_timer.sv ----
`timescale 1ns/1ps
module delay_timer
   import charger_cfg_pkg::*;
#(
   parameter int SHORT_CYCLES = DELAY_SHORT_CYCLES,
   parameter int LONG_CYCLES = DELAY_LONG_CYCLES
) (
   // Clock and control.
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Request side.
   input wire logic start,
   input wire logic sel_long,
   input wire logic abort,
   // Result.
   output logic busy,
   output logic done
);

   localparam int CW = $clog2(LONG_CYCLES + 1);

   typedef enum logic [1:0] {
      T_IDLE = 2'b01,
      T_RUN = 2'b10
   } timer_state_t;

   timer_state_t state_r;
   logic [CW-1:0] count_r;
   logic done_r;

   // A zero count or a long delay shorter than the short one cannot be timed.
   if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES) begin : g_bad_cycles
      $error("delay_timer: need 1 <= SHORT_CYCLES <= LONG_CYCLES");
   end

   // A new start reloads the count even while running, unless abort is high in
   // the same cycle, so the delay measures from the latest request.
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= T_IDLE;
         count_r <= '0;
         done_r <= 1'b0;
      end else if (ce) begin
         done_r <= 1'b0;
         if (abort) begin
            state_r <= T_IDLE;
            count_r <= '0;
         end else if (start) begin
            state_r <= T_RUN;
            count_r <= sel_long ? CW'(LONG_CYCLES - 1) : CW'(SHORT_CYCLES - 1);
         end else begin
            unique case (state_r)
               T_IDLE: begin
                  count_r <= '0;
               end
               T_RUN: begin
                  if (count_r == '0) begin
                     state_r <= T_IDLE;
                     done_r <= 1'b1;
                  end else begin
                     count_r <= count_r - CW'(1);
                  end
               end
            endcase
         end
      end
   end

   assign busy = (state_r == T_RUN);
   assign done = done_r;

endmodule

// ---- host_model.sv ----
`timescale 1ns/1ps
module host_model
   import charger_cfg_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Register port towards the bank.
   output reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   // Idle address and data carry the inverse of the last value, so nothing stale can match.
   initial req = {1'b0, 1'b0, 8'hFF, 8'hFF};

   // One write strobe, held up to the edge that takes it.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= {1'b0, 1'b0, ~a, ~d};
   endtask

   // One read strobe, then a bounded wait for the valid pulse.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int n;
      @(posedge clk);
      req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= {1'b0, 1'b0, ~a, 8'hFF};
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         #1;
         if (rvalid === 1'b1) begin
            d = rdata;
            ok = 1'b1;
         end else begin
            @(posedge clk);
         end
      end
   endtask
endmodule

// ---- status_pin_driver.sv ----
`timescale 1ns/1ps
module status_pin_driver
   import charger_cfg_pkg::*;
(
   // Clock and control.
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Configuration.
   input wire logic pin_function,
   input wire logic manual_select,
   input wire logic manual_level,
   // Internal indications.
   input wire logic fault,
   input wire logic detection_done,
   // Open-drain pin.
   output logic pin_out,
   output logic pin_oe
);

   logic pin_oe_r;

   // The pin only ever pulls low; a released pin is pulled high outside.
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_oe_r <= 1'b0;
      end else if (ce) begin
         if (manual_select) begin
            pin_oe_r <= manual_level;
         end else begin
            pin_oe_r <= pin_function ? detection_done : fault;
         end
      end
   end

   assign pin_out = 1'b0;
   assign pin_oe = pin_oe_r;

endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
   import charger_cfg_pkg::*;
();
   // Short delays keep the run brief; the delay timing expectations derive from these.
   localparam int SHORT = 10;
   localparam int LONG = 50;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   reg_req_t req;
   logic [7:0] rdata;
   logic rvalid;
   logic [6:0] tc_code = 7'h2A;
   logic [6:0] prog_code = 7'h55;
   logic [6:0] adaptor = 7'h5A;
   logic warm = 1'b0, cool = 1'b0, floor_hit = 1'b0;
   logic fault = 1'b0, det_done = 1'b0, ship_req = 1'b0;
   power_ctrl_t pc;
   thermal_ctrl_t tc;
   logic fet_off, ship_on, pin_out, pin_oe;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   // Clock and a free cycle count used to time the delays.
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   charger_config_register_bank #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut_u (
      .clk(clk), .reset(reset), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
      .type_c_limit_code(tc_code), .input_current_limit_code(prog_code),
      .adaptor_type(adaptor), .warm_zone(warm), .cool_zone(cool),
      .current_at_floor(floor_hit), .fault(fault), .detection_done(det_done),
      .ship_mode_request(ship_req), .power_ctrl(pc), .thermal_ctrl(tc),
      .battery_fet_off(fet_off), .ship_mode_enter(ship_on),
      .second_status_pin_out(pin_out), .second_status_pin_oe(pin_oe));

   host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Outputs follow configuration one edge later; three edges leave margin.
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.wr_reg(a, d);
      settle();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bit ok;
      host_u.rd_reg(a, d, ok);
      check({7'h00, ok}, 8'h01);
      check(d, exp);
      // A read that never answered ends the run through the closing report.
      if (!ok) begin
         results();
      end
   endtask

   // Waits for a level on the ship or FET output and judges the elapsed cycles.
   task automatic wait_sig(input bit fet, input logic lvl, input int t0, input int lo,
                           input int hi);
      int n;
      int d;
      for (n = 0; n < 200; n++) begin
         if ((fet ? fet_off : ship_on) === lvl) break;
         @(posedge clk);
         #1;
      end
      if (n == 200) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, (fet ? fet_off : ship_on), lvl);
         results();
      end
      d = cyc - t0;
      check(8'((d >= lo && d <= hi) ? lo : d), 8'(lo));
   endtask

   task automatic t_reset;
      rd_chk(8'hC3, 8'h00);
      rd_chk(8'hC6, 8'h0C);
      rd_chk(8'hC7, 8'h7C);
      rd_chk(8'hD5, 8'h08);
      rd_chk(8'hC4, 8'h5A);
      rd_chk(8'h10, 8'h00);
      check({7'h00, pc.limit_from_type_c}, 8'h01);
      check({7'h00, pc.skip_mode_auto}, 8'h01);
      check({7'h00, tc.extreme_zone_enable}, 8'h01);
      check({6'h00, fet_off, ship_on}, 8'h00);
      $display("reset values done");
   endtask

   task automatic t_masks;
      logic [7:0] a[4] = '{8'hC3, 8'hC6, 8'hC7, 8'hD5};
      logic [7:0] m[4] = '{8'h99, 8'h3E, 8'hFF, 8'h0F};
      logic [7:0] r[4] = '{8'h00, 8'h0C, 8'h7C, 8'h08};
      for (int i = 0; i < 4; i++) begin
         host_u.wr_reg(a[i], 8'hFF);
         rd_chk(a[i], m[i]);
         host_u.wr_reg(a[i], r[i]);
         rd_chk(a[i], r[i]);
      end
      host_u.wr_reg(8'hC4, 8'h00);
      rd_chk(8'hC4, 8'h5A);
      host_u.wr_reg(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h00);
      $display("register masks done");
   endtask

   task automatic t_power;
      wr(8'hC3, 8'h80);
      check({pc.limit_from_type_c, pc.limit_code}, 8'h55);
      wr(8'hC3, 8'h00);
      check({pc.limit_from_type_c, pc.limit_code}, 8'hAA);
      for (int i = 0; i < 4; i++) begin
         wr(8'hC3, 8'(i << 3));
         check({6'h00, pc.input_regulation_threshold}, 8'(i));
      end
      wr(8'hC3, 8'h01);
      check({7'h00, pc.skip_mode_auto}, 8'h00);
      wr(8'hC6, 8'h2C);
      check({6'h00, pc.converter_off, pc.standby}, 8'h03);
      wr(8'hC6, 8'h0C);
      check({6'h00, pc.converter_off, pc.standby}, 8'h00);
      $display("power controls done");
   endtask

   task automatic t_thermal;
      logic [7:0] cv[4] = '{8'h00, 8'h00, 8'h64, 8'h96};
      logic [7:0] cc[4] = '{8'h64, 8'h64, 8'h14, 8'h32};
      wr(8'hC7, 8'h80);
      check({7'h00, tc.extreme_zone_enable}, 8'h00);
      @(posedge clk);
      warm <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(8'hC7, 8'(i << 5));
         check(tc.cv_drop_mv, cv[i]);
      end
      @(posedge clk);
      warm <= 1'b0;
      cool <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(8'hC7, 8'(i << 3));
         check(tc.cc_percent, cc[i]);
      end
      wr(8'hC7, 8'h60);
      check(tc.cv_drop_mv, 8'h00);
      @(posedge clk);
      floor_hit <= 1'b1;
      settle();
      check(tc.cv_drop_mv, 8'h96);
      wr(8'hD5, 8'h00);
      check(tc.cv_drop_mv, 8'h00);
      wr(8'hC7, 8'h05);
      check({5'h00, tc.spread_enable, tc.spread_pattern, tc.spread_envelope}, 8'h06);
      wr(8'hC7, 8'h03);
      check({5'h00, tc.spread_enable, tc.spread_pattern, tc.spread_envelope}, 8'h05);
      wr(8'hC7, 8'h06);
      check({7'h00, tc.spread_enable}, 8'h00);
      $display("thermal controls done");
   endtask

   task automatic t_pin;
      @(posedge clk);
      fault <= 1'b1;
      wr(8'hD5, 8'h02);
      check({6'h00, pin_out, pin_oe}, 8'h00);
      wr(8'hD5, 8'h03);
      check({6'h00, pin_out, pin_oe}, 8'h01);
      wr(8'hD5, 8'h00);
      check({7'h00, pin_oe}, 8'h01);
      wr(8'hD5, 8'h04);
      check({7'h00, pin_oe}, 8'h00);
      @(posedge clk);
      det_done <= 1'b1;
      fault <= 1'b0;
      settle();
      check({7'h00, pin_oe}, 8'h01);
      $display("status pin done");
   endtask

   // Raises the ship request and times entry from that edge.
   task automatic ship_try(input logic [7:0] cfg, input int lo, input int hi);
      int t0;
      wr(8'hC6, cfg);
      @(posedge clk);
      ship_req <= 1'b1;
      #1;
      t0 = cyc;
      wait_sig(1'b0, 1'b1, t0, lo, hi);
      @(posedge clk);
      ship_req <= 1'b0;
      #1;
      wait_sig(1'b0, 1'b0, cyc, 1, 3);
   endtask

   task automatic t_ship;
      int t0;
      ship_try(8'h08, 1, 3);
      ship_try(8'h0C, SHORT, SHORT + 4);
      ship_try(8'h0E, LONG, LONG + 4);
      @(posedge clk);
      ship_req <= 1'b1;
      repeat (6) @(posedge clk);
      ship_req <= 1'b0;
      repeat (2) @(posedge clk);
      ship_req <= 1'b1;
      #1;
      t0 = cyc;
      wait_sig(1'b0, 1'b1, t0, LONG, LONG + 4);
      @(posedge clk);
      ship_req <= 1'b0;
      $display("ship mode done");
   endtask

   // Sets the reset bit, clears it at once and times the minimum off period.
   task automatic fet_try(input logic [7:0] cfg, input int cycles);
      int t0;
      host_u.wr_reg(8'hC6, cfg | 8'h10);
      #1;
      t0 = cyc;
      host_u.wr_reg(8'hC6, cfg);
      #1;
      check({7'h00, fet_off}, 8'h01);
      wait_sig(1'b1, 1'b0, t0, cycles - 1, cycles + 4);
   endtask

   task automatic t_fet;
      fet_try(8'h04, SHORT);
      fet_try(8'h0C, LONG);
      wr(8'hC6, 8'h14);
      repeat (LONG + 10) @(posedge clk);
      #1;
      check({7'h00, fet_off}, 8'h01);
      wr(8'hC6, 8'h04);
      check({7'h00, fet_off}, 8'h00);
      $display("battery FET done");
   endtask

   // Reset is held for ten cycles, then each scenario runs in turn.
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      settle();
      t_reset();
      t_masks();
      t_power();
      t_thermal();
      t_pin();
      t_ship();
      t_fet();
      results();
   end
endmodule
